//--- rtl/pbr_pace_chan.sv
// One pace channel: measures a pace pulse and reports log-coded results.
// Assumes pulse_in and height_in are synchronous to mclk.
`timescale 1ns/1ps
`include "pbr_regs.svh"
module pbr_pace_chan
    import pbr_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Sample rate and frame events
    input  wire logic         sample_en,
    input  wire logic         frame_clr,
    // Pulse from detector
    input  wire logic         pulse_in,
    input  wire logic [15:0]  height_in,
    // Result
    output pbr_pace_ch_t      result_q
);
    logic [15:0]  width_cnt_q;
    logic [15:0]  peak_q;
    logic         pulse_q;
    pbr_pace_ch_t result_d;
    wire          trail;

    function automatic logic [3:0] floor_log2(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 1; i < 16; i++)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    assign trail = pulse_q & ~pulse_in;

    always_comb
    begin
        result_d = result_q;
        if (frame_clr)
        begin
            result_d.detected = 1'b0;
        end
        if (trail)
        begin
            result_d.detected   = 1'b1;
            result_d.width_log  = (floor_log2(width_cnt_q) == 4'h0) ? 3'h0 :
                (floor_log2(width_cnt_q) > `PBR_WIDTH_MAX) ? 3'h7 :
                3'(floor_log2(width_cnt_q) - 4'h1);
            result_d.height_log = floor_log2(peak_q);
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pulse_q     <= 1'b0;
            width_cnt_q <= 16'h0000;
            peak_q      <= 16'h0000;
            result_q    <= '0;
        end
        else
        begin
            pulse_q  <= pulse_in;
            result_q <= result_d;
            if (!pulse_in)
            begin
                width_cnt_q <= 16'h0000;
                peak_q      <= 16'h0000;
            end
            else
            begin
                if (sample_en && width_cnt_q != 16'hffff)
                begin
                    width_cnt_q <= width_cnt_q + 16'h0001;
                end
                if (height_in > peak_q)
                begin
                    peak_q <= height_in;
                end
            end
        end
    end
endmodule

//--- rtl/pbr_pkg.sv
// Types shared by the pace and breath result registers.
// Assumes the constants header is included where numbers are needed.
package pbr_pkg;
    typedef struct packed {
        logic       detected;
        logic [2:0] width_log;
        logic [3:0] height_log;
    } pbr_pace_ch_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
    } pbr_req_t;

    typedef enum logic [1:0] {
        PBR_OUT_IDLE  = 2'b00,
        PBR_OUT_HIGH  = 2'b01,
        PBR_OUT_LOW   = 2'b10
    } pbr_out_t;
endpackage

//--- rtl/pbr_regs.svh
// Offsets, field positions and rate constants of the pace and breath
// result registers. Assumes a 100 MHz mclk and a 32-bit register word.
//
// Contract
// - A detected flag rises at the trailing edge of its pace pulse.
// - A detected flag reads 1 if a pulse ended in this frame, else 0.
// - The 3-bit width field holds log2(width)-1 in 128 kHz samples.
// - The 4-bit height field holds log2(height) in converter steps.
// - In fast frame mode pace and amplitude words go as 16-bit halves.
// - In fast register mode the full 32-bit word is returned unsplit.
// - The breath amplitude is a 24-bit unsigned value in bits 23:0.
// - The breath angle is a 24-bit fraction of a turn, step 2pi/2^24.
// - The breath angle is never streamed, only read explicitly.
// - These registers exist only in the full-feature variant.
`ifndef PBR_REGS_SVH
`define PBR_REGS_SVH
`define PBR_ADDR_PACE       8'h1a
`define PBR_ADDR_AMPL       8'h1b
`define PBR_ADDR_ANGLE      8'h1c
`define PBR_WORD_RESET      24'h000000
`define PBR_CH1_LSB         0
`define PBR_CH2_LSB         8
`define PBR_CH3_LSB         16
`define PBR_SAMPLE_HZ       128000
`define PBR_CLK_HZ          100000000
`define PBR_SAMPLE_DIV      (`PBR_CLK_HZ / `PBR_SAMPLE_HZ)
`define PBR_WIDTH_MAX       4'h8
`endif

//--- rtl/pbr_result_regs.sv
// Pace and breath result registers with read port and frame word output.
// Assumes pace pulses, breath results and host requests are mclk-synchronous.
`timescale 1ns/1ps
`include "pbr_regs.svh"
module pbr_result_regs
    import pbr_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Variant and mode
    input  wire logic         full_variant,
    input  wire logic         fast_rate,
    // Frame events
    input  wire logic         frame_load,
    // Pace detector
    input  wire logic [2:0]   pace_pulse,
    input  wire logic [15:0]  pace_height,
    // Breath demodulator
    input  wire logic         breath_valid,
    input  wire logic [23:0]  breath_ampl_in,
    input  wire logic [23:0]  breath_angle_in,
    // Host register access
    input  wire pbr_req_t     host_req,
    output logic [31:0]       rd_data_q,
    output logic              rd_valid_q,
    output logic              rd_hit_q,
    // Frame stream
    input  wire logic [7:0]   frame_addr,
    input  wire logic         frame_req,
    output logic [31:0]       frame_word_q,
    output logic              frame_valid_q,
    output logic              frame_half_q
);
    pbr_pace_ch_t  ch_q [3];
    logic [23:0]   ampl_q;
    logic [23:0]   angle_q;
    logic [9:0]    div_q;
    logic          sample_en_q;
    pbr_out_t      out_st_q;
    logic [23:0]   hold_q;
    logic [7:0]    hold_addr_q;
    wire  [23:0]   pace_word;
    wire  [31:0]   frame_full;
    wire           fr_ok;
    wire           rd_ok;

    function automatic logic [31:0] pack_word(input logic [7:0] a,
                                              input logic [23:0] d);
        return {a, d};
    endfunction

    // Sample rate divider
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q       <= 10'h000;
            sample_en_q <= 1'b0;
        end
        else
        begin
            sample_en_q <= (div_q == 10'(`PBR_SAMPLE_DIV - 1));
            div_q <= (div_q == 10'(`PBR_SAMPLE_DIV - 1)) ? 10'h000
                                                        : div_q + 10'h001;
        end
    end

    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        pbr_pace_chan u_chan (
            .mclk      (mclk),
            .reset_n   (reset_n),
            .sample_en (sample_en_q),
            .frame_clr (frame_load),
            .pulse_in  (pace_pulse[c] & full_variant),
            .height_in (pace_height),
            .result_q  (ch_q[c])
        );
    end

    assign pace_word = {ch_q[2], ch_q[1], ch_q[0]};

    // Breath results; no write path exists
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ampl_q  <= `PBR_WORD_RESET;
            angle_q <= `PBR_WORD_RESET;
        end
        else if (breath_valid && full_variant)
        begin
            ampl_q  <= breath_ampl_in;
            angle_q <= breath_angle_in;
        end
    end

    // Register read; writes ignored
    assign rd_ok = host_req.rd && full_variant &&
        (host_req.addr == `PBR_ADDR_PACE || host_req.addr == `PBR_ADDR_AMPL
         || host_req.addr == `PBR_ADDR_ANGLE);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_q  <= 32'h00000000;
            rd_valid_q <= 1'b0;
            rd_hit_q   <= 1'b0;
        end
        else
        begin
            rd_valid_q <= host_req.rd;
            rd_hit_q   <= rd_ok;
            if (!rd_ok)
            begin
                rd_data_q <= 32'h00000000;
            end
            else if (host_req.addr == `PBR_ADDR_PACE)
            begin
                // Full word in register mode
                rd_data_q <= pack_word(host_req.addr, pace_word);
            end
            else if (host_req.addr == `PBR_ADDR_AMPL)
            begin
                rd_data_q <= pack_word(host_req.addr, ampl_q);
            end
            else
            begin
                rd_data_q <= pack_word(host_req.addr, angle_q);
            end
        end
    end

    // Frame stream: angle excluded, split in halves at fast rate
    assign fr_ok = frame_req && full_variant &&
        (frame_addr == `PBR_ADDR_PACE || frame_addr == `PBR_ADDR_AMPL);
    assign frame_full = pack_word(hold_addr_q, hold_q);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_st_q      <= PBR_OUT_IDLE;
            hold_q        <= 24'h000000;
            hold_addr_q   <= 8'h00;
            frame_word_q  <= 32'h00000000;
            frame_valid_q <= 1'b0;
            frame_half_q  <= 1'b0;
        end
        else
        begin
            frame_valid_q <= 1'b0;
            frame_half_q  <= 1'b0;
            unique case (out_st_q)
                PBR_OUT_IDLE:
                begin
                    if (fr_ok)
                    begin
                        hold_q      <= (frame_addr == `PBR_ADDR_PACE)
                                       ? pace_word : ampl_q;
                        hold_addr_q <= frame_addr;
                        out_st_q    <= fast_rate ? PBR_OUT_HIGH : PBR_OUT_LOW;
                    end
                end
                PBR_OUT_HIGH:
                begin
                    frame_word_q  <= {16'h0000, frame_full[31:16]};
                    frame_valid_q <= 1'b1;
                    frame_half_q  <= 1'b1;
                    out_st_q      <= PBR_OUT_LOW;
                end
                PBR_OUT_LOW:
                begin
                    frame_word_q  <= fast_rate ? {16'h0000, frame_full[15:0]}
                                               : frame_full;
                    frame_valid_q <= 1'b1;
                    out_st_q      <= PBR_OUT_IDLE;
                end
                default:
                begin
                    out_st_q <= PBR_OUT_IDLE;
                end
            endcase
        end
    end
endmodule

//--- sim/pbr_host_model.sv
// Host controller model issuing register reads and stream requests.
// Assumes mclk-synchronous requests, spaced as the block allows.
`timescale 1ns/1ps
module pbr_host_model
    import pbr_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Host access
    output pbr_req_t         host_req,
    input  wire logic [31:0] rd_data_q,
    input  wire logic        rd_valid_q,
    input  wire logic        rd_hit_q,
    // Stream
    output logic [7:0]       frame_addr,
    output logic             frame_req,
    input  wire logic [31:0] frame_word_q,
    input  wire logic        frame_valid_q,
    input  wire logic        frame_half_q
);
    initial
    begin
        host_req = '0;
        frame_addr = 8'h00;
        frame_req = 1'b0;
    end
    // Angle only by explicit read
    task automatic access(input logic [7:0] a, input logic w,
                          output logic [33:0] r);
        @(posedge mclk);
        #1;
        host_req = '{addr: a, rd: !w, wr: w};
        @(posedge mclk);
        #1;
        host_req = '{addr: ~a, rd: 1'b0, wr: 1'b0};
        r = {rd_valid_q, rd_hit_q, rd_data_q};
    endtask
    task automatic stream(input logic [7:0] a, output logic [67:0] r);
        @(posedge mclk);
        #1;
        frame_addr = a;
        frame_req = 1'b1;
        @(posedge mclk);
        #1;
        frame_req = 1'b0;
        frame_addr = ~a;
        @(posedge mclk);
        #1;
        r[67:34] = {frame_valid_q, frame_half_q, frame_word_q};
        @(posedge mclk);
        #1;
        r[33:0] = {frame_valid_q, frame_half_q, frame_word_q};
        @(posedge mclk);
    endtask
endmodule

//--- sim/pbr_result_monitor.sv
// Port checker for the result registers.
// Assumes it is bound to pbr_result_regs.
`timescale 1ns/1ps
module pbr_result_monitor
    import pbr_pkg::*;
(
    // Clock and mode
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        full_variant,
    input wire logic        fast_rate,
    // Host access
    input wire pbr_req_t    host_req,
    input wire logic [31:0] rd_data_q,
    input wire logic        rd_valid_q,
    input wire logic        rd_hit_q,
    // Stream
    input wire logic [7:0]  frame_addr,
    input wire logic        frame_req,
    input wire logic [31:0] frame_word_q,
    input wire logic        frame_valid_q,
    input wire logic        frame_half_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire hit_c = full_variant
        && host_req.addr inside {8'h1a, 8'h1b, 8'h1c};
    property p_rd_ans;
        host_req.rd |=> rd_valid_q;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read unanswered");
    property p_rd_hit;
        host_req.rd && hit_c |=> rd_hit_q
            && rd_data_q[31:24] == $past(host_req.addr);
    endproperty
    a_rd_hit: assert property (p_rd_hit)
        else $error("bad hit");
    property p_rd_miss;
        host_req.rd && !hit_c |=> !rd_hit_q && rd_data_q == 32'h00000000;
    endproperty
    a_rd_miss: assert property (p_rd_miss)
        else $error("bad miss");
    property p_refuse;
        frame_req && (frame_addr == 8'h1c || !full_variant)
            |=> !frame_valid_q [*3];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("word streamed");
    property p_stream;
        frame_req && full_variant && frame_addr inside {8'h1a, 8'h1b}
            |-> ##2 frame_valid_q;
    endproperty
    a_stream: assert property (p_stream)
        else $error("no word");
    property p_split;
        frame_valid_q && frame_half_q |=> frame_valid_q && !frame_half_q;
    endproperty
    a_split: assert property (p_split)
        else $error("half lost");
    property p_whole;
        frame_valid_q && !fast_rate |-> !frame_half_q
            && frame_word_q[31:24] inside {8'h1a, 8'h1b};
    endproperty
    a_whole: assert property (p_whole)
        else $error("bad word");
    property p_rst;
        $rose(reset_n) |-> !rd_valid_q && !frame_valid_q && !rd_hit_q;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset output");
endmodule
bind pbr_result_regs pbr_result_monitor pbr_result_monitor_i (
    .mclk(mclk), .reset_n(reset_n), .full_variant(full_variant),
    .fast_rate(fast_rate), .host_req(host_req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_hit_q(rd_hit_q),
    .frame_addr(frame_addr), .frame_req(frame_req),
    .frame_word_q(frame_word_q), .frame_valid_q(frame_valid_q),
    .frame_half_q(frame_half_q));

//--- sim/tb_pbr_result_regs.sv
// Self-checking bench for the result registers.
// Assumes the host model drives all host and stream requests.
`timescale 1ns/1ps
module tb_pbr_result_regs
    import pbr_pkg::*;
;
    logic        mclk, reset_n, full_variant, fast_rate, frame_load;
    logic [2:0]  pace_pulse;
    logic [15:0] pace_height;
    logic        breath_valid;
    logic [23:0] breath_ampl_in, breath_angle_in;
    pbr_req_t    host_req;
    logic [31:0] rd_data_q, frame_word_q;
    logic        rd_valid_q, rd_hit_q, frame_req;
    logic        frame_valid_q, frame_half_q;
    logic [7:0]  frame_addr;
    logic [33:0] r;
    logic [67:0] f;
    int          err_count, checks_done, cycles;
    pbr_result_regs pbr_result_regs_i (.*);
    pbr_host_model pbr_host_model_i (.*);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    initial
    begin
        {reset_n, fast_rate, frame_load, pace_pulse, breath_valid} = '0;
        {pace_height, breath_ampl_in, breath_angle_in} = '0;
        full_variant = 1'b1;
        step(3);
        reset_n = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            pbr_host_model_i.access(8'h1a + 8'(i), 1'b0, r);
            chk(r, {2'b11, 8'h1a + 8'(i), 24'h000000});
        end
        pbr_host_model_i.access(8'h1d, 1'b0, r);
        chk(r, {2'b10, 32'h00000000});
        breath_valid = 1'b1;
        breath_ampl_in = 24'habcdef;
        breath_angle_in = 24'h400000;
        step(1);
        {breath_valid, breath_ampl_in, breath_angle_in} = '0;
        pbr_host_model_i.access(8'h1b, 1'b0, r);
        chk(r, {2'b11, 32'h1babcdef});
        pbr_host_model_i.access(8'h1c, 1'b0, r);
        chk(r, {2'b11, 32'h1c400000});
        pbr_host_model_i.access(8'h1b, 1'b1, r);
        chk(r, 34'h000000000);
        pbr_host_model_i.access(8'h1b, 1'b0, r);
        chk(r, {2'b11, 32'h1babcdef});
        pbr_host_model_i.stream(8'h1b, f);
        chk(f, {2'b10, 32'h1babcdef, 2'b00, 32'h1babcdef});
        pbr_host_model_i.stream(8'h1c, f);
        chk({f[67], f[33]}, 2'b00);
        fast_rate = 1'b1;
        pbr_host_model_i.stream(8'h1b, f);
        chk({f[67:66], f[49:34], f[33:32], f[15:0]},
            {2'b11, 16'h1bab, 2'b10, 16'hcdef});
        pbr_host_model_i.access(8'h1b, 1'b0, r);
        chk(r, {2'b11, 32'h1babcdef});
        fast_rate = 1'b0;
        pace_height = 16'h0400;
        pace_pulse = 3'b010;
        step(2000);
        pbr_host_model_i.access(8'h1a, 1'b0, r);
        chk(r[15], 1'b0);
        step(2684);
        pace_pulse = 3'b000;
        pace_height = 16'h0000;
        step(2);
        pbr_host_model_i.access(8'h1a, 1'b0, r);
        chk(r, {2'b11, 32'h1a009a00});
        frame_load = 1'b1;
        step(1);
        frame_load = 1'b0;
        pbr_host_model_i.access(8'h1a, 1'b0, r);
        chk(r[15], 1'b0);
        reset_n = 1'b0;
        step(1);
        reset_n = 1'b1;
        pbr_host_model_i.access(8'h1b, 1'b0, r);
        chk(r, {2'b11, 32'h1b000000});
        full_variant = 1'b0;
        pbr_host_model_i.access(8'h1a, 1'b0, r);
        chk(r, {2'b10, 32'h00000000});
        pbr_host_model_i.stream(8'h1b, f);
        chk({f[67], f[33]}, 2'b00);
        summarize();
    end
endmodule
